// >>> cie_core.sv
// cie_core: executes one issued instruction on W, file registers, pc
// assumes a single AXI4-Lite master on aclk, one write and one read
`timescale 1ns/10ps
`default_nettype none
module cie_core #(
  parameter int STACK_DEPTH = 8,
  parameter int PRE_W = 8,
  parameter int WDT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int FILE_N = 1 << cie_pkg::F_W;
  localparam int SP_W = $clog2(STACK_DEPTH);

  cie_pkg::cie_state_t state_ff;
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic w_held_ff;
  logic [3:0] op_ff;
  logic dest_ff;
  logic [10:0] k_ff;
  logic [12:0] pc_ff;
  logic [7:0] w_ff;
  logic [7:0] page_ff;
  logic [6:0] fidx_ff;
  logic z_ff;
  logic to_ff;
  logic pwr_down_ff;
  logic skip_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [WDT_W-1:0] wdt_ff;
  logic [7:0] file_ff [FILE_N];
  logic [12:0] stack_ff [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [1:0] bresp_ff;
  logic bvalid_ff;
  logic rvalid_ff;

  logic [6:0] f_sel;
  logic [7:0] opnd;
  logic [7:0] res;
  logic wr_acc;
  logic wr_file;
  logic upd_z;
  logic two_cyc;
  logic exec_go;
  logic wr_fire;
  logic wr_ok;
  logic issue;
  logic bus_fwr;
  logic [7:0] wbyte;
  logic [12:0] stack_top;
  logic [SP_W-1:0] sp_prev;

  assign f_sel = k_ff[cie_pkg::F_W-1:0];
  assign opnd = file_ff[f_sel];
  assign exec_go = (state_ff == cie_pkg::ST_EXEC);
  assign wbyte = wdata_ff[7:0];
  assign sp_prev = sp_ff - SP_W'(1);
  assign stack_top = stack_ff[sp_prev];

  // execution datapath
  always_comb
  begin
    res = cie_pkg::BYTE_ZERO;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_z = 1'b0;
    two_cyc = 1'b0;
    unique case (op_ff)
      cie_pkg::OPC_CALL: two_cyc = 1'b1;
      cie_pkg::OPC_CLR_REG:
      begin
        wr_file = 1'b1;
        upd_z = 1'b1;
      end
      cie_pkg::OPC_CLR_ACC:
      begin
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      cie_pkg::OPC_COMP, cie_pkg::OPC_DEC, cie_pkg::OPC_DEC_SKIP:
      begin
        if (op_ff == cie_pkg::OPC_COMP)
          res = ~opnd;
        else
          res = opnd - cie_pkg::BYTE_ONE;
        wr_acc = (dest_ff == cie_pkg::DEST_ACC);
        wr_file = (dest_ff == cie_pkg::DEST_FILE);
        upd_z = (op_ff != cie_pkg::OPC_DEC_SKIP);
        two_cyc = (op_ff == cie_pkg::OPC_DEC_SKIP) &&
                  (res == cie_pkg::BYTE_ZERO);
      end
      default: ;
    endcase
  end

  // bus write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= cie_pkg::BYTE_ZERO;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
    end
    else if (wr_fire)
      w_held_ff <= 1'b0;
  end

  // writes that touch execution state are refused while busy
  always_comb
  begin
    unique case (awaddr_ff)
      cie_pkg::ADDR_INSTR, cie_pkg::ADDR_FDATA:
        wr_ok = (state_ff == cie_pkg::ST_IDLE);
      cie_pkg::ADDR_PAGE, cie_pkg::ADDR_FIDX: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  assign issue = wr_fire && wr_ok && (awaddr_ff == cie_pkg::ADDR_INSTR);
  assign bus_fwr = wr_fire && wr_ok && (awaddr_ff == cie_pkg::ADDR_FDATA);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= cie_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? cie_pkg::RESP_OKAY : cie_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      page_ff <= cie_pkg::BYTE_ZERO;
      fidx_ff <= 7'h00;
    end
    else if (wr_fire && s_axi_wstrb[0])
    begin
      if (awaddr_ff == cie_pkg::ADDR_PAGE)
        page_ff <= wbyte;
      if (awaddr_ff == cie_pkg::ADDR_FIDX)
        fidx_ff <= wbyte[cie_pkg::F_W-1:0];
    end
  end

  // instruction latch and sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_ff <= cie_pkg::OPC_NOP;
      dest_ff <= cie_pkg::DEST_ACC;
      k_ff <= 11'h000;
    end
    else if (issue)
    begin
      op_ff <= wdata_ff[cie_pkg::OP_LSB +: cie_pkg::OP_W];
      dest_ff <= wdata_ff[cie_pkg::DEST_BIT];
      k_ff <= wdata_ff[cie_pkg::K_W-1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= cie_pkg::ST_IDLE;
    else
      unique case (state_ff)
        cie_pkg::ST_IDLE:
          if (issue)
            state_ff <= cie_pkg::ST_EXEC;
        cie_pkg::ST_EXEC:
          state_ff <= two_cyc ? cie_pkg::ST_SECOND : cie_pkg::ST_IDLE;
        cie_pkg::ST_SECOND: state_ff <= cie_pkg::ST_IDLE;
        default: state_ff <= cie_pkg::ST_IDLE;
      endcase
  end

  // program counter and return stack
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_ff <= cie_pkg::PC_RST;
      skip_ff <= 1'b0;
    end
    else if (exec_go)
    begin
      skip_ff <= (op_ff == cie_pkg::OPC_DEC_SKIP) && two_cyc;
      if (op_ff == cie_pkg::OPC_CALL)
        pc_ff <= {page_ff[cie_pkg::PAGE_HI:cie_pkg::PAGE_LO],
                  k_ff};
      else if (two_cyc)
        pc_ff <= pc_ff + 13'h0002;
      else
        pc_ff <= pc_ff + 13'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sp_ff <= '0;
    else if (exec_go && op_ff == cie_pkg::OPC_CALL)
      sp_ff <= sp_ff + SP_W'(1);
  end

  for (genvar i = 0; i < STACK_DEPTH; i++)
  begin : g_stack
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        stack_ff[i] <= cie_pkg::PC_RST;
      else if (exec_go && op_ff == cie_pkg::OPC_CALL &&
               sp_ff == SP_W'(i))
        stack_ff[i] <= pc_ff + 13'h0001;
    end
  end

  // working register, file registers and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_ff <= cie_pkg::BYTE_ZERO;
    else if (exec_go && wr_acc)
      w_ff <= res;
  end

  for (genvar i = 0; i < FILE_N; i++)
  begin : g_file
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        file_ff[i] <= cie_pkg::BYTE_ZERO;
      else if (exec_go && wr_file && f_sel == 7'(i))
        file_ff[i] <= res;
      else if (bus_fwr && s_axi_wstrb[0] && fidx_ff == 7'(i))
        file_ff[i] <= wbyte;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      z_ff <= 1'b0;
    else if (exec_go && upd_z)
      z_ff <= (res == cie_pkg::BYTE_ZERO);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      to_ff <= 1'b1;
      pwr_down_ff <= 1'b1;
    end
    else if (exec_go && op_ff == cie_pkg::OPC_WDT_CLR)
    begin
      to_ff <= 1'b1;
      pwr_down_ff <= 1'b1;
    end
  end

  // watchdog count with prescaler, cleared by the instruction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_ff <= '0;
      wdt_ff <= '0;
    end
    else if (exec_go && op_ff == cie_pkg::OPC_WDT_CLR)
    begin
      pre_ff <= '0;
      wdt_ff <= '0;
    end
    else
    begin
      pre_ff <= pre_ff + PRE_W'(1);
      if (&pre_ff)
        wdt_ff <= wdt_ff + WDT_W'(1);
    end
  end

  // read channel
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= cie_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= cie_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      unique case (s_axi_araddr)
        cie_pkg::ADDR_INSTR:
          rdata_ff <= {12'h000, op_ff, 3'h0, dest_ff, 1'b0, k_ff};
        cie_pkg::ADDR_STATUS:
          rdata_ff <= {27'h0, skip_ff, pwr_down_ff, to_ff, z_ff,
                       state_ff != cie_pkg::ST_IDLE};
        cie_pkg::ADDR_PC: rdata_ff <= {19'h0, pc_ff};
        cie_pkg::ADDR_WREG: rdata_ff <= {24'h0, w_ff};
        cie_pkg::ADDR_PAGE: rdata_ff <= {24'h0, page_ff};
        cie_pkg::ADDR_FIDX: rdata_ff <= {25'h0, fidx_ff};
        cie_pkg::ADDR_FDATA: rdata_ff <= {24'h0, file_ff[fidx_ff]};
        cie_pkg::ADDR_STACK: rdata_ff <= {19'h0, stack_top};
        cie_pkg::ADDR_WDT: rdata_ff <= 32'(wdt_ff);
        default: rresp_ff <= cie_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic go_call;
  logic go_dec;
  assign go_call = exec_go && op_ff == cie_pkg::OPC_CALL;
  assign go_dec = exec_go && (op_ff == cie_pkg::OPC_DEC ||
                  op_ff == cie_pkg::OPC_DEC_SKIP);

  call_push_a: assert property (go_call |=>
    stack_top == $past(pc_ff) + 13'h0001)
    else $error("call return address wrong");
  call_low_a: assert property (go_call |=>
    pc_ff[10:0] == k_ff)
    else $error("call target low bits wrong");
  call_page_a: assert property (go_call |=>
    pc_ff[12:11] == $past(page_ff[4:3]))
    else $error("call page bits wrong");
  call_cycles_a: assert property (go_call |=>
    state_ff == cie_pkg::ST_SECOND && $stable(z_ff)
    ##1 state_ff == cie_pkg::ST_IDLE)
    else $error("call not two cycles or flag moved");
  wdt_clear_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_WDT_CLR |=> wdt_ff == '0)
    else $error("watchdog count not cleared");
  pre_clear_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_WDT_CLR |=> pre_ff == '0)
    else $error("prescaler not cleared");
  wdt_flags_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_WDT_CLR |=> to_ff && pwr_down_ff)
    else $error("time-out or power-down flag not set");
  clr_reg_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_CLR_REG |=>
    file_ff[f_sel] == cie_pkg::BYTE_ZERO && z_ff)
    else $error("clear register failed");
  clr_acc_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_CLR_ACC |=>
    w_ff == cie_pkg::BYTE_ZERO && z_ff)
    else $error("clear accumulator failed");
  comp_dest_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_COMP |=>
    (dest_ff ? file_ff[f_sel] : w_ff) == ~$past(opnd) &&
    z_ff == ($past(opnd) == 8'hFF))
    else $error("complement result or zero flag wrong");
  dec_val_a: assert property (go_dec |=>
    (dest_ff ? file_ff[f_sel] : w_ff) == $past(opnd) - 8'h01)
    else $error("decrement result wrong");
  dec_skip_a: assert property (
    exec_go && op_ff == cie_pkg::OPC_DEC_SKIP |=> $stable(z_ff) &&
    (pc_ff == $past(pc_ff) + (($past(opnd) == 8'h01) ? 13'h0002
                                                     : 13'h0001)))
    else $error("decrement skip wrong");

  call_seen_c: cover property (go_call ##1
    state_ff == cie_pkg::ST_SECOND ##1 state_ff == cie_pkg::ST_IDLE);
  skip_seen_c: cover property (exec_go && op_ff ==
    cie_pkg::OPC_DEC_SKIP && two_cyc);
  wdt_seen_c: cover property (exec_go && op_ff ==
    cie_pkg::OPC_WDT_CLR);
  refuse_c: cover property (wr_fire && !wr_ok);
endmodule
`default_nettype wire

// >>> cie_pkg.sv
// cie_pkg: constants for the instruction execute block
// assumes a 32-bit AXI4-Lite register bus, byte addressing
package cie_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_WREG = 8'h0C;
  localparam logic [7:0] ADDR_PAGE = 8'h10;
  localparam logic [7:0] ADDR_FIDX = 8'h14;
  localparam logic [7:0] ADDR_FDATA = 8'h18;
  localparam logic [7:0] ADDR_STACK = 8'h1C;
  localparam logic [7:0] ADDR_WDT = 8'h20;
  // instruction word fields
  localparam int OP_LSB = 16;
  localparam int OP_W = 4;
  localparam int DEST_BIT = 12;
  localparam int K_W = 11;
  localparam int F_W = 7;
  // operation codes
  localparam logic [3:0] OPC_NOP = 4'h0;
  localparam logic [3:0] OPC_CALL = 4'h1;
  localparam logic [3:0] OPC_WDT_CLR = 4'h2;
  localparam logic [3:0] OPC_CLR_REG = 4'h3;
  localparam logic [3:0] OPC_CLR_ACC = 4'h4;
  localparam logic [3:0] OPC_COMP = 4'h5;
  localparam logic [3:0] OPC_DEC = 4'h6;
  localparam logic [3:0] OPC_DEC_SKIP = 4'h7;
  // status read bits
  localparam int ST_BUSY = 0;
  localparam int ST_Z = 1;
  localparam int ST_TO = 2;
  localparam int ST_PWR_DOWN = 3;
  localparam int ST_SKIP = 4;
  // program counter layout
  localparam int PC_W = 13;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  // destination select values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // reset values, byte constants, bus responses and sequencer states
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_SECOND = 3'b100
  } cie_state_t;
endpackage

// >>> cpu_instruction_execute_tb.sv
// cpu_instruction_execute_tb: self-checking bench for cie_core
// assumes an AXI4-Lite master driven here, aclk at 100 MHz
`timescale 1ns/10ps
`default_nettype none
module cpu_instruction_execute_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int err_count = 0;
  int check_count = 0;
  logic [1:0] rsp;
  logic [31:0] v;

  always #5 aclk = ~aclk;

  cie_core cie_core_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string msg);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp, msg);
  endtask

  function automatic logic [31:0] ins(input logic [3:0] op, input logic d,
                                      input logic [10:0] k);
    ins = 32'h0;
    ins[cie_pkg::OP_LSB +: cie_pkg::OP_W] = op;
    ins[cie_pkg::DEST_BIT] = d;
    ins[10:0] = k;
  endfunction

  // issue one instruction and poll until the core is idle again
  task automatic exec(input logic [3:0] op, input logic d,
                      input logic [10:0] k);
    logic [31:0] s;
    logic [1:0] r;
    wr(cie_pkg::ADDR_INSTR, ins(op, d, k), r);
    chk(r, cie_pkg::RESP_OKAY, "instr resp");
    do rd(cie_pkg::ADDR_STATUS, s, r); while (s[cie_pkg::ST_BUSY] !== 1'b0);
  endtask

  task automatic set_file(input logic [7:0] d);
    wr(cie_pkg::ADDR_FIDX, 32'h5, rsp);
    wr(cie_pkg::ADDR_FDATA, {24'h0, d}, rsp);
  endtask

  task automatic t_reset_map();
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v, 32'h0000000C, "status after reset");
    rd_chk(cie_pkg::ADDR_PC, 32'h0, "pc after reset");
    rd(8'h40, v, rsp);
    chk(rsp, cie_pkg::RESP_SLVERR, "unmapped read");
    wr(8'h40, 32'h1, rsp);
    chk(rsp, cie_pkg::RESP_SLVERR, "unmapped write");
    wr(cie_pkg::ADDR_STATUS, 32'h0, rsp);
    chk(rsp, cie_pkg::RESP_SLVERR, "status write");
  endtask

  task automatic t_clear();
    set_file(8'hA5);
    exec(cie_pkg::OPC_CLR_REG, 1'b1, 11'h005);
    rd_chk(cie_pkg::ADDR_FDATA, 32'h0, "clear reg");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b1, "clear reg z");
    exec(cie_pkg::OPC_COMP, cie_pkg::DEST_ACC, 11'h005);
    rd_chk(cie_pkg::ADDR_WREG, 32'hFF, "comp to w");
    rd_chk(cie_pkg::ADDR_FDATA, 32'h0, "comp file kept");
    exec(cie_pkg::OPC_CLR_ACC, 1'b0, 11'h000);
    rd_chk(cie_pkg::ADDR_WREG, 32'h0, "clear w");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b1, "clear w z");
    rd_chk(cie_pkg::ADDR_PC, 32'h3, "pc step");
    rd_chk(cie_pkg::ADDR_FIDX, 32'h5, "index readback");
  endtask

  task automatic t_comp_dec();
    set_file(8'h5A);
    exec(cie_pkg::OPC_COMP, cie_pkg::DEST_FILE, 11'h005);
    rd_chk(cie_pkg::ADDR_FDATA, 32'hA5, "comp to file");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b0, "comp z");
    set_file(8'h01);
    exec(cie_pkg::OPC_DEC, cie_pkg::DEST_FILE, 11'h005);
    rd_chk(cie_pkg::ADDR_FDATA, 32'h0, "dec to zero");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b1, "dec z set");
    exec(cie_pkg::OPC_DEC, cie_pkg::DEST_ACC, 11'h005);
    rd_chk(cie_pkg::ADDR_WREG, 32'hFF, "dec wrap");
    rd_chk(cie_pkg::ADDR_FDATA, 32'h0, "dec file kept");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b0, "dec z clear");
    rd_chk(cie_pkg::ADDR_PC, 32'h6, "pc after dec");
  endtask

  task automatic t_skip();
    set_file(8'h02);
    exec(cie_pkg::OPC_DEC_SKIP, cie_pkg::DEST_FILE, 11'h005);
    rd_chk(cie_pkg::ADDR_FDATA, 32'h1, "skip dec");
    rd_chk(cie_pkg::ADDR_PC, 32'h7, "no skip pc");
    exec(cie_pkg::OPC_DEC_SKIP, cie_pkg::DEST_FILE, 11'h005);
    rd_chk(cie_pkg::ADDR_FDATA, 32'h0, "skip dec zero");
    rd_chk(cie_pkg::ADDR_PC, 32'h9, "skip pc");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b0, "skip keeps z");
    chk(v[cie_pkg::ST_SKIP], 1'b1, "skip flag");
  endtask

  task automatic t_call();
    exec(cie_pkg::OPC_CLR_ACC, 1'b0, 11'h000);
    wr(cie_pkg::ADDR_PAGE, 32'h18, rsp);
    exec(cie_pkg::OPC_CALL, 1'b0, 11'h7FF);
    rd_chk(cie_pkg::ADDR_PC, 32'h1FFF, "call pc");
    rd_chk(cie_pkg::ADDR_STACK, 32'hB, "return addr");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_Z], 1'b1, "call keeps z");
    wr(cie_pkg::ADDR_PAGE, 32'hE7, rsp);
    exec(cie_pkg::OPC_CALL, 1'b0, 11'h123);
    rd_chk(cie_pkg::ADDR_PC, 32'h0123, "call page low");
    rd_chk(cie_pkg::ADDR_PAGE, 32'hE7, "page readback");
    rd_chk(cie_pkg::ADDR_STACK, 32'h0, "return wrap");
  endtask

  task automatic t_wdt();
    // let the prescaler roll over so the count is non-zero first
    repeat (300) @(posedge aclk);
    rd(cie_pkg::ADDR_WDT, v, rsp);
    chk(v == 32'h0, 1'b0, "wdt running");
    exec(cie_pkg::OPC_WDT_CLR, 1'b0, 11'h000);
    rd_chk(cie_pkg::ADDR_WDT, 32'h0, "wdt cleared");
    rd(cie_pkg::ADDR_STATUS, v, rsp);
    chk(v[cie_pkg::ST_TO], 1'b1, "time-out set");
    chk(v[cie_pkg::ST_PWR_DOWN], 1'b1, "power-down set");
    exec(cie_pkg::OPC_NOP, 1'b0, 11'h000);
    rd_chk(cie_pkg::ADDR_PC, 32'h125, "no-op pc");
    exec(4'hF, 1'b1, 11'h7AB);
    rd_chk(cie_pkg::ADDR_PC, 32'h126, "unused op pc");
    rd_chk(cie_pkg::ADDR_INSTR, ins(4'hF, 1'b1, 11'h7AB), "instr readback");
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_clear();
    t_comp_dec();
    t_skip();
    t_call();
    t_wdt();
    complete_run();
  end

  // cuts a hang short well beyond the expected run time
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
